/* lwx_consts.svh */
// constants for the latch-write, test and xor execution block
`ifndef LWX_CONSTS_SVH
`define LWX_CONSTS_SVH

`define LWX_OP_TLW_HI    6'h29
`define LWX_OP_TSZ       8'h33
`define LWX_OP_XIM       8'hb4
`define LWX_OP_XFL_HI    7'h06
`define LWX_TSEL_BIT     9
`define LWX_DEST_BIT     8
`define LWX_Q_LAST       2'h3
`define LWX_LATCH_RST    16'h0000
`define LWX_WORK_RST     8'h00

`endif

/* lwx_pkg.sv */
// types for the latch-write, test and xor execution block
`default_nettype none

package lwx_pkg;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_LATCH_LOAD,
		OP_TEST_SKIP,
		OP_XOR_IMM,
		OP_XOR_FILE
	} lwx_op_t;

	typedef struct packed {
		logic       wrEn;
		logic [7:0] addr;
		logic [7:0] data;
	} lwx_file_wr_t;

endpackage

`default_nettype wire

/* lwx_phase_gen.sv */
// four-phase instruction cycle generator
`timescale 1ns/1ps
`default_nettype none
`include "lwx_consts.svh"

module lwx_phase_gen (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       srst,
	// phase outputs
	output var  logic [1:0] phase,
	output var  logic       cycleEnd
);

	logic [1:0] phase_r;
	logic [1:0] phase_nxt;

	always_comb begin
		phase_nxt = phase_r + 2'h1;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			phase_r <= 2'h0;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	assign phase    = phase_r;
	assign cycleEnd = (phase_r == `LWX_Q_LAST);

endmodule // lwx_phase_gen

`default_nettype wire

/* lwx_exec.sv */
// execution of table latch load, test-skip and two xor instructions
//
// Behaviour
// (RULE1) The latch-load opcode 1010 01tx copies the file register into the high byte when t is 1, else the low byte.
// (RULE2) The loaded latch byte is the data a later program-memory write instruction transfers.
// (RULE3) The latch load keeps the other byte and every flag unchanged and takes one cycle.
// (RULE4) The test-skip instruction is decoded from upper byte 0011 0011 with the file address below.
// (RULE5) A zero file register makes test-skip discard the fetched next instruction, running a no-op, flags unchanged.
// (RULE6) The xor-immediate instruction xors the working register with the literal into the working register in one cycle.
// (RULE7) The xor-immediate instruction is decoded from upper byte 1011 0100 with the literal below.
// (RULE8) The xor-file instruction 0000 110d xors working register and file, result to the working register when d is 0.
// (RULE9) With d set the xor-file result goes back to the file register and the working register stays.
// (RULE10) Both xors set the zero flag on a zero result and clear it otherwise, touching no other flag.
// (RULE11) The sixteen-bit table latch is the word the program-memory write stores at the table pointer.
`timescale 1ns/1ps
`default_nettype none
`include "lwx_consts.svh"

module lwx_exec (
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  srst,
	// instruction in, held for one instruction cycle
	input  wire logic                  instrValid,
	input  wire logic [15:0]           instr,
	// file register read data for instr[7:0]
	input  wire logic [7:0]            fileRdData,
	// file register write back
	output var  lwx_pkg::lwx_file_wr_t fileWr,
	// core state
	output var  logic [7:0]            workingRegister,
	output var  logic                  zeroFlag,
	output var  logic [15:0]           tableLatch,
	output var  logic                  skipNext,
	output var  logic                  cycleEnd,
	output var  logic                  instrDone
);

	// ---------------------------------------------
	// phase generator
	// ---------------------------------------------
	logic qEnd;

	lwx_phase_gen u_phase (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.phase    (),
		.cycleEnd (qEnd)
	);

	// ---------------------------------------------
	// state registers
	// ---------------------------------------------
	logic [7:0]            workReg_r, workReg_nxt;
	logic                  zero_r,    zero_nxt;
	logic [15:0]           latch_r,   latch_nxt;
	logic                  skip_r,    skip_nxt;
	lwx_pkg::lwx_file_wr_t fwr_r,     fwr_nxt;
	logic                  end_r,     end_nxt;
	logic                  done_r,    done_nxt;

	// ---------------------------------------------
	// decode
	// ---------------------------------------------
	lwx_pkg::lwx_op_t op;
	logic             commit;
	logic [7:0]       xorRes;

	always_comb begin
		op = lwx_pkg::OP_NONE;
		if (!instrValid) begin
			op = lwx_pkg::OP_NONE;
		// (RULE5) discard the prefetched word
		end else if (skip_r) begin
			op = lwx_pkg::OP_NONE;
		// (RULE1) latch load decode
		end else if (instr[15:10] == `LWX_OP_TLW_HI) begin
			op = lwx_pkg::OP_LATCH_LOAD;
		// (RULE4) test skip decode
		end else if (instr[15:8] == `LWX_OP_TSZ) begin
			op = lwx_pkg::OP_TEST_SKIP;
		// (RULE7) xor immediate decode
		end else if (instr[15:8] == `LWX_OP_XIM) begin
			op = lwx_pkg::OP_XOR_IMM;
		// (RULE8) xor file decode
		end else if (instr[15:9] == `LWX_OP_XFL_HI) begin
			op = lwx_pkg::OP_XOR_FILE;
		end
	end

	// ---------------------------------------------
	// operand select and commit
	// ---------------------------------------------
	always_comb begin
		commit = qEnd && (op != lwx_pkg::OP_NONE);
		xorRes = workReg_r ^ ((op == lwx_pkg::OP_XOR_IMM) ? instr[7:0] : fileRdData);
	end

	// ---------------------------------------------
	// working register and zero flag
	// ---------------------------------------------
	always_comb begin
		workReg_nxt = workReg_r;
		zero_nxt    = zero_r;
		if (commit) begin
			case (op)
				// (RULE6) (RULE10) xor immediate result
				lwx_pkg::OP_XOR_IMM: begin
					workReg_nxt = xorRes;
					zero_nxt    = (xorRes == 8'h00);
				end
				// (RULE8) (RULE9) (RULE10) xor file result
				lwx_pkg::OP_XOR_FILE: begin
					zero_nxt = (xorRes == 8'h00);
					if (!instr[`LWX_DEST_BIT]) begin
						workReg_nxt = xorRes;
					end
				end
				// (RULE3) (RULE5) flags left alone
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			workReg_r <= `LWX_WORK_RST;
			zero_r    <= 1'b0;
		end else begin
			workReg_r <= workReg_nxt;
			zero_r    <= zero_nxt;
		end
	end

	// ---------------------------------------------
	// table latch
	// ---------------------------------------------
	always_comb begin
		latch_nxt = latch_r;
		// (RULE1) (RULE3) load one latch byte
		if (commit && (op == lwx_pkg::OP_LATCH_LOAD)) begin
			// (RULE2) (RULE11) latch feeds table write
			if (instr[`LWX_TSEL_BIT]) begin
				latch_nxt[15:8] = fileRdData;
			end else begin
				latch_nxt[7:0] = fileRdData;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			latch_r <= `LWX_LATCH_RST;
		end else begin
			latch_r <= latch_nxt;
		end
	end

	// ---------------------------------------------
	// skip request
	// ---------------------------------------------
	always_comb begin
		skip_nxt = skip_r;
		// (RULE4) (RULE5) skip on zero file
		if (qEnd) begin
			skip_nxt = commit && (op == lwx_pkg::OP_TEST_SKIP) && (fileRdData == 8'h00);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			skip_r <= 1'b0;
		end else begin
			skip_r <= skip_nxt;
		end
	end

	// ---------------------------------------------
	// file write back
	// ---------------------------------------------
	always_comb begin
		fwr_nxt = '0;
		// (RULE9) result back to file
		if (commit && (op == lwx_pkg::OP_XOR_FILE) && instr[`LWX_DEST_BIT]) begin
			fwr_nxt.wrEn = 1'b1;
			fwr_nxt.addr = instr[7:0];
			fwr_nxt.data = xorRes;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fwr_r <= '0;
		end else begin
			fwr_r <= fwr_nxt;
		end
	end

	// ---------------------------------------------
	// cycle strobes
	// ---------------------------------------------
	always_comb begin
		end_nxt  = qEnd;
		done_nxt = commit;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			end_r  <= 1'b0;
			done_r <= 1'b0;
		end else begin
			end_r  <= end_nxt;
			done_r <= done_nxt;
		end
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	assign workingRegister = workReg_r;
	assign zeroFlag        = zero_r;
	assign tableLatch      = latch_r;
	assign skipNext        = skip_r;
	assign fileWr          = fwr_r;
	assign cycleEnd        = end_r;
	assign instrDone       = done_r;

endmodule // lwx_exec

`default_nettype wire

/* lwx_exec_sva.sv */
// checker for lwx_exec
`timescale 1ns/1ps
`default_nettype none
module lwx_exec_sva (
	input wire logic                  sys_clk,
	input wire logic                  srst,
	input wire logic [15:0]           instr,
	input wire logic [7:0]            fileRdData,
	input wire lwx_pkg::lwx_file_wr_t fileWr,
	input wire logic [7:0]            workingRegister,
	input wire logic                  zeroFlag,
	input wire logic [15:0]           tableLatch,
	input wire logic                  skipNext,
	input wire logic                  cycleEnd,
	input wire logic                  instrDone
);
	logic [15:0] pI, pL;
	logic [7:0]  pF, pW;
	logic        pZ;
	always_ff @(posedge sys_clk) begin
		pI <= instr;
		pF <= fileRdData;
		pW <= workingRegister;
		pL <= tableLatch;
		pZ <= zeroFlag;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	a_xim_work:
	assert property (instrDone && pI[15:8] == 8'hb4 |-> workingRegister == (pW ^ pI[7:0])
		&& zeroFlag == (workingRegister == 8'h00)) else $error("xor imm wrong");
	a_xfl_work:
	assert property (instrDone && pI[15:8] == 8'h0c |-> workingRegister == (pW ^ pF) && !fileWr.wrEn
		&& zeroFlag == (workingRegister == 8'h00)) else $error("xor file to working reg wrong");
	a_xfl_file:
	assert property (instrDone && pI[15:8] == 8'h0d |-> fileWr == {1'b1, pI[7:0], pW ^ pF}
		&& workingRegister == pW && zeroFlag == ((pW ^ pF) == 8'h00)) else $error("xor file to file wrong");
	a_latch_byte:
	assert property (instrDone && pI[15:10] == 6'h29 |-> tableLatch == (pI[9] ? {pF, pL[7:0]} : {pL[15:8], pF}))
		else $error("latch byte wrong");
	a_latch_keep:
	assert property (instrDone && pI[15:10] == 6'h29 |-> zeroFlag == pZ && workingRegister == pW && !fileWr.wrEn)
		else $error("latch load side effect");
	a_latch_stable:
	assert property (!(instrDone && pI[15:10] == 6'h29) |-> tableLatch == pL) else $error("latch moved");
	a_skip_zero:
	assert property (instrDone && pI[15:8] == 8'h33 |-> skipNext == (pF == 8'h00) && zeroFlag == pZ)
		else $error("test skip wrong");
	a_skip_hold:
	assert property ($rose(skipNext) |-> skipNext [*4]) else $error("skip too short");
	a_done_cycle:
	assert property (instrDone |-> cycleEnd) else $error("done off cycle");
	a_skip_discard:
	assert property ($fell(skipNext) |-> !instrDone) else $error("skipped word executed");
endmodule // lwx_exec_sva
bind lwx_exec lwx_exec_sva u_sva (.sys_clk, .srst, .instr, .fileRdData, .fileWr, .workingRegister,
	.zeroFlag, .tableLatch, .skipNext, .cycleEnd, .instrDone);
`default_nettype wire

/* lwx_exec_tb.sv */
// testbench for lwx_exec
`timescale 1ns/1ps
`default_nettype none
module lwx_exec_tb;
	logic                  sys_clk = 0, srst = 1, instrValid = 0;
	logic [15:0]           instr = 16'h0000;
	logic [7:0]            fileRdData = 8'h00;
	lwx_pkg::lwx_file_wr_t fileWr;
	logic [7:0]            workingRegister;
	logic                  zeroFlag, skipNext, cycleEnd, instrDone;
	logic [15:0]           tableLatch;
	int                    n_mismatch = 0, comparisons = 0, cyc = 0;
	always #10 sys_clk = ~sys_clk;
	lwx_exec u_dut (.sys_clk, .srst, .instrValid, .instr, .fileRdData, .fileWr, .workingRegister,
		.zeroFlag, .tableLatch, .skipNext, .cycleEnd, .instrDone);
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one instruction cycle, entered at the negedge showing cycleEnd
	task automatic run(input logic [15:0] i, input logic [7:0] f, input logic v);
		instr = i;
		fileRdData = f;
		instrValid = v;
		do @(negedge sys_clk); while (cycleEnd !== 1'b1);
	endtask
	task automatic conclude;
		$display("counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic t_xor;
		run(16'hb4b5, 8'h00, 1'b1);
		chk(workingRegister, 8'hb5);
		chk(zeroFlag, 1'b0);
		run(16'hb4b5, 8'h00, 1'b1);
		chk(zeroFlag, 1'b1);
		run(16'hb4b5, 8'h00, 1'b1);
		run(16'h0d55, 8'haf, 1'b1);
		chk(fileWr, {1'b1, 8'h55, 8'h1a});
		chk(workingRegister, 8'hb5);
		@(negedge sys_clk);
		chk({fileWr.wrEn, instrDone, cycleEnd}, 3'h0);
		run(16'h0c20, 8'hb5, 1'b1);
		chk({fileWr.wrEn, workingRegister, zeroFlag}, {1'b0, 8'h00, 1'b1});
		$display("xor test done");
	endtask
	task automatic t_latch;
		run(16'ha420, 8'hb7, 1'b1);
		chk(tableLatch, 16'h00b7);
		chk(zeroFlag, 1'b1);
		run(16'ha721, 8'h3c, 1'b1);
		chk(tableLatch, 16'h3cb7);
		chk(instrDone, 1'b1);
		$display("latch test done");
	endtask
	task automatic t_skip;
		run(16'h3310, 8'h00, 1'b1);
		chk({skipNext, zeroFlag}, 2'h3);
		run(16'hb4ff, 8'h00, 1'b1);
		chk({instrDone, skipNext, workingRegister}, 10'h000);
		run(16'h3311, 8'h01, 1'b1);
		chk({skipNext, instrDone}, 2'h1);
		run(16'h0000, 8'h00, 1'b0);
		chk(instrDone, 1'b0);
		run(16'hffff, 8'h00, 1'b1);
		chk({instrDone, tableLatch}, 17'h03cb7);
		$display("skip test done");
	endtask
	task automatic t_reset;
		logic [3:0] clks;
		clks = 4'h0;
		run(16'hb4b5, 8'h00, 1'b1);
		run(16'h0d33, 8'hb5, 1'b1);
		chk(fileWr, {1'b1, 8'h33, 8'h00});
		chk({zeroFlag, workingRegister}, 9'h1b5);
		run(16'h3310, 8'h00, 1'b1);
		instrValid = 1'b0;
		srst = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk(fileWr, 17'h00000);
		chk(tableLatch, 16'h0000);
		chk({workingRegister, zeroFlag, skipNext, cycleEnd, instrDone}, 12'h000);
		srst = 1'b0;
		do begin
			@(negedge sys_clk);
			clks++;
		end while (cycleEnd !== 1'b1);
		chk(clks, 4'h4);
		run(16'hb45a, 8'h00, 1'b1);
		chk({workingRegister, zeroFlag}, 9'h0b4);
		$display("reset test done");
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_mismatch++;
			conclude;
		end
	end
	initial begin
		repeat (16) @(negedge sys_clk);
		srst = 0;
		do @(negedge sys_clk); while (cycleEnd !== 1'b1);
		t_xor;
		t_latch;
		t_skip;
		t_reset;
		conclude;
	end
endmodule // lwx_exec_tb
`default_nettype wire
